// *** sioc_pkg.sv ***
// constants for the switching io status and control block
package sioc_pkg;
	localparam int CNT_W = 16;
	localparam logic [7:0] OUT_RESET = 8'h00;
	localparam logic [15:0] IN_RESET = 16'h0000;
	localparam int OB_SW2 = 1;
	localparam int OB_CNT_CLR = 5;
	localparam int IB0_IN1 = 0;
	localparam int IB0_SW2 = 1;
	localparam int IB0_IN3 = 2;
	localparam int IB0_IN4 = 3;
	localparam int IB1_CMP = 8 + 2;
	localparam int IB1_TGL = 8 + 3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	typedef enum logic {SIOC_SINGLE, SIOC_REPEAT} sioc_mode_t;
endpackage

// *** sioc_cnt_if.sv ***
// counter link between the control block and the event counter
interface sioc_cnt_if;
	import sioc_pkg::*;
	logic clr;
	logic event_in;
	logic [CNT_W-1:0] cmp_val;
	logic over;
	logic over_evt;
	modport ctl (output clr, event_in, cmp_val, input over, over_evt);
	modport cnt (input clr, event_in, cmp_val, output over, over_evt);
endinterface

// *** sioc_event_counter.sv ***
// event counter of the output 2 activation function
module sioc_event_counter (
	input wire logic i_clk,
	input wire logic i_rst,
	sioc_cnt_if.cnt c
);
	import sioc_pkg::*;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic over_r, over_nxt;
	always_comb begin
		cnt_nxt = cnt_r;
		if (c.clr) begin
			cnt_nxt = CNT_ZERO;
		end else if (c.event_in && cnt_r != CNT_MAX) begin
			cnt_nxt = cnt_r + CNT_ONE;
		end
		over_nxt = cnt_nxt > c.cmp_val;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= CNT_ZERO;
			over_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			over_r <= over_nxt;
		end
	end
	assign c.over = over_r;
	// each step past the comparison value counts as one exceed event
	assign c.over_evt = !c.clr && c.event_in && (cnt_r != CNT_MAX)
		&& (cnt_r >= c.cmp_val);
	clear_zero_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		c.clr |=> cnt_r == CNT_ZERO && !over_r)
		else $error("counter not cleared");
endmodule

// *** sioc_switching_io.sv ***
// switching io status and control process image
//
// Overview of operation
// - inputs 1,3,4 shown in byte 0 bits 0,2,3
// - output 2 level shown in byte 0 bit 1
// - bit 1.2 set while counter exceeds compare
// - bit 1.3 toggles per exceed in repeat mode
// - output bit 0.1 drives switching output 2
// - rising edge of bit 0.5 clears counter
// - the clear also resets bits 1.2 and 1.3
module sioc_switching_io (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_sw_in1,
	input wire logic i_sw_in3,
	input wire logic i_sw_in4,
	input wire logic i_activation_event,
	input wire logic [sioc_pkg::CNT_W-1:0] i_cmp_value,
	input wire sioc_pkg::sioc_mode_t i_switching_output_config,
	input wire logic [7:0] i_out_image,
	input wire logic i_out_image_wr,
	output logic [15:0] o_in_image,
	output logic [7:0] o_out_image,
	output logic o_sw_out2
);
	import sioc_pkg::*;
	// a 0 to 1 change between the stored and the new bit value
	function automatic logic rise_f(input logic new_bit,
		input logic old_bit);
		return new_bit && !old_bit;
	endfunction
	// ==========================================================
	// pin synchronisers, two flops per pin
	logic [2:0] pin_raw, pin_sync;
	assign pin_raw = {i_sw_in4, i_sw_in3, i_sw_in1};
	for (genvar p = 0; p < 3; p++) begin : g_sync
		logic s1_r, s2_r;
		always_ff @(posedge i_clk or posedge i_rst) begin
			if (i_rst) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
			end else begin
				s1_r <= pin_raw[p];
				s2_r <= s1_r;
			end
		end
		assign pin_sync[p] = s2_r;
	end
	// ==========================================================
	// output image and counter clear
	sioc_cnt_if cif ();
	logic [7:0] out_r, out_nxt;
	logic clr_r, clr_nxt;
	logic sw2_r, sw2_nxt;
	logic cmp_r, cmp_nxt;
	logic tgl_r, tgl_nxt;
	logic [15:0] img_r, img_nxt;
	always_comb begin
		out_nxt = out_r;
		clr_nxt = 1'b0;
		if (i_out_image_wr) begin
			out_nxt = i_out_image;
			// only a 0 to 1 change clears
			clr_nxt = rise_f(i_out_image[OB_CNT_CLR],
				out_r[OB_CNT_CLR]);
		end
		sw2_nxt = out_nxt[OB_SW2];
	end
	assign cif.clr = clr_r;
	assign cif.event_in = i_activation_event;
	assign cif.cmp_val = i_cmp_value;
	sioc_event_counter u_cnt (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.c(cif.cnt)
	);
	// ==========================================================
	// status flags and input image
	always_comb begin
		cmp_nxt = cif.over;
		tgl_nxt = tgl_r;
		if (clr_r) begin
			cmp_nxt = 1'b0;
			tgl_nxt = 1'b0;
		end else if (cif.over_evt
			&& i_switching_output_config == SIOC_REPEAT) begin
			tgl_nxt = !tgl_r;
		end
		img_nxt = IN_RESET;
		img_nxt[IB0_IN1] = pin_sync[0];
		img_nxt[IB0_SW2] = sw2_r;
		img_nxt[IB0_IN3] = pin_sync[1];
		img_nxt[IB0_IN4] = pin_sync[2];
		img_nxt[IB1_CMP] = cmp_r;
		img_nxt[IB1_TGL] = tgl_r;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			out_r <= OUT_RESET;
			clr_r <= 1'b0;
			sw2_r <= 1'b0;
			cmp_r <= 1'b0;
			tgl_r <= 1'b0;
			img_r <= IN_RESET;
		end else begin
			out_r <= out_nxt;
			clr_r <= clr_nxt;
			sw2_r <= sw2_nxt;
			cmp_r <= cmp_nxt;
			tgl_r <= tgl_nxt;
			img_r <= img_nxt;
		end
	end
	assign o_in_image = img_r;
	assign o_out_image = out_r;
	assign o_sw_out2 = sw2_r;
	// ==========================================================
	// assertions
	sequence clr_edge_s;
		i_out_image_wr
			&& rise_f(i_out_image[OB_CNT_CLR], out_r[OB_CNT_CLR]);
	endsequence
	sequence flags_zero_s;
		##2 !cmp_r && !tgl_r;
	endsequence
	sequence repeat_evt_s;
		cif.over_evt && !clr_r
			&& i_switching_output_config == SIOC_REPEAT;
	endsequence
	sequence tgl_flip_s;
		tgl_r != $past(tgl_r);
	endsequence
	clear_edge_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		clr_edge_s |=> clr_r)
		else $error("clear missing after rising edge");
	fall_noop_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_out_image_wr && !i_out_image[OB_CNT_CLR] |=> !clr_r)
		else $error("clear on falling edge");
	flags_clear_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		clr_edge_s |-> flags_zero_s)
		else $error("flags not reset by clear");
	out2_drive_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_out_image_wr |=> o_sw_out2 == $past(i_out_image[OB_SW2]))
		else $error("output 2 level wrong");
	out2_report_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		##1 o_in_image[IB0_SW2] == $past(o_sw_out2))
		else $error("output 2 state not reported");
	reserved_zero_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_in_image[15:12] == 4'h0 && o_in_image[9:4] == 6'h00)
		else $error("reserved input bit set");
	input_pass_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		##3 o_in_image[IB0_IN1] == $past(i_sw_in1, 3))
		else $error("input 1 not reported");
	cmp_track_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!clr_r |=> cmp_r == $past(cif.over))
		else $error("compare flag wrong");
	toggle_hold_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_switching_output_config == SIOC_SINGLE && !clr_r
		|=> $stable(tgl_r))
		else $error("toggle in single mode");
	input3_pass_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		##3 o_in_image[IB0_IN3] == $past(i_sw_in3, 3))
		else $error("input 3 not reported");
	input4_pass_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		##3 o_in_image[IB0_IN4] == $past(i_sw_in4, 3))
		else $error("input 4 not reported");
	out_store_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_out_image_wr |=> o_out_image == $past(i_out_image))
		else $error("output image not stored");
	out_hold_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!i_out_image_wr |=> $stable(o_out_image))
		else $error("output image changed without write");
	out2_hold_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!i_out_image_wr |=> $stable(o_sw_out2))
		else $error("output 2 changed without write");
	out2_only_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_sw_out2 == o_out_image[OB_SW2])
		else $error("output 2 follows a reserved bit");
	no_clear_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!(i_out_image_wr && i_out_image[OB_CNT_CLR]) |=> !clr_r)
		else $error("clear without a write of bit 5");
	clear_once_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		clr_r |=> !clr_r)
		else $error("clear pulse longer than one cycle");
	clear_flags_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		clr_r |=> !cmp_r && !tgl_r)
		else $error("flags kept over a clear");
	cmp_report_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		##1 o_in_image[IB1_CMP] == $past(cmp_r))
		else $error("compare flag not reported");
	tgl_report_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		##1 o_in_image[IB1_TGL] == $past(tgl_r))
		else $error("toggle flag not reported");
	toggle_flip_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		repeat_evt_s |=> tgl_flip_s)
		else $error("toggle missing on exceed");
	toggle_only_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!cif.over_evt && !clr_r |=> $stable(tgl_r))
		else $error("toggle without exceed");
	exceed_over_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		cif.over_evt |=> cif.over)
		else $error("exceed event without compare state");
endmodule

// *** sioc_ctl_model.sv ***
// controller model driving the cyclic output image
module sioc_ctl_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [7:0] i_img,
	output logic [7:0] o_img,
	output logic o_wr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_img = 8'h00;
		o_wr = 1'b0;
	end
	always @(posedge i_clk) begin
		o_wr <= i_go;
		if (i_go) begin
			o_img <= i_img;
		end
	end
endmodule

// *** switching_io_status_control_bench.sv ***
// bench for the switching io status and control block
module switching_io_status_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import sioc_pkg::*;
	logic i_clk = 0, i_rst = 1, go = 0, ev = 0, chk = 0, wr, o_sw_out2;
	logic [2:0] pins = 3'h0;
	logic [7:0] img = 8'h00, oimg, o_out_image;
	logic [15:0] o_in_image;
	logic [15:0] cmpv = 16'h0002;
	logic [24:0] q[$];
	logic cmpf = 0, tgl = 0, prev5 = 0;
	sioc_mode_t mode = SIOC_SINGLE;
	int fails = 0, num_checks = 0, cnt = 0;
	bit [31:0] seed = 32'h0000_52c8;
	initial forever #50 i_clk = ~i_clk;
	sioc_ctl_model sioc_ctl_model_inst (.i_clk(i_clk), .i_go(go),
		.i_img(img), .o_img(oimg), .o_wr(wr));
	sioc_switching_io sioc_switching_io_inst (.i_clk(i_clk), .i_rst(i_rst),
		.i_sw_in1(pins[0]), .i_sw_in3(pins[1]), .i_sw_in4(pins[2]),
		.i_activation_event(ev), .i_cmp_value(cmpv),
		.i_switching_output_config(mode), .i_out_image(oimg),
		.i_out_image_wr(wr), .o_in_image(o_in_image),
		.o_out_image(o_out_image), .o_sw_out2(o_sw_out2));
	function automatic bit [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cmp_img(input logic [24:0] e);
		num_checks++;
		if ({o_sw_out2, o_out_image, o_in_image} !== e) begin
			fails++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e,
				{o_sw_out2, o_out_image, o_in_image});
		end
	endtask
	// one write, optional event, then a noted expectation
	task automatic step(input logic [7:0] b, input logic e);
		logic [7:0] v;
		v = b | (8'(rnd()) & 8'hdd);
		go <= 1'b1;
		img <= v;
		pins <= 3'(rnd());
		@(posedge i_clk);
		go <= 1'b0;
		ev <= e;
		@(posedge i_clk);
		ev <= 1'b0;
		if (v[5] && !prev5) begin
			cnt = 0;
			tgl = 0;
		end
		prev5 = v[5];
		if (e) begin
			cnt++;
			if (cnt > cmpv && mode == SIOC_REPEAT) begin
				tgl = ~tgl;
			end
		end
		cmpf = cnt > cmpv;
		repeat (6) @(posedge i_clk);
		q.push_back({v[1], v, 4'h0, tgl, cmpf, 2'h0, 4'h0, pins[2:1], v[1],
			pins[0]});
		chk <= 1'b1;
		@(posedge i_clk);
		chk <= 1'b0;
	endtask
	always @(posedge i_clk) begin
		if (chk) begin
			cmp_img(q.pop_front());
		end
	end
	task automatic test_done();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		step(8'h22, 1'b0);
		repeat (3) step(8'h22, 1'b1);
		$display("single mode compare test done");
		step(8'h00, 1'b0);
		mode <= SIOC_REPEAT;
		cmpv <= 16'h0001;
		step(8'h20, 1'b0);
		repeat (5) step(8'h02, 1'b1);
		$display("repeat mode toggle test done");
		test_done();
	end
endmodule
